// File: sic_consts.vh
// Constants for the stepper indexer control and protection block
`ifndef SIC_CONSTS_VH
`define SIC_CONSTS_VH

// Register byte offsets
`define SIC_OFS_STATUS    8'h00
`define SIC_OFS_IRQ_STAT  8'h04
`define SIC_OFS_IRQ_MASK  8'h08
`define SIC_OFS_CTRL      8'h0c

// Status register fields
`define SIC_ST_DRIVE      0
`define SIC_ST_ASLEEP     1
`define SIC_ST_OC         2
`define SIC_ST_OT         3
`define SIC_ST_UV         4
`define SIC_ST_HOME       5
`define SIC_ST_POS_LSB    8
`define SIC_ST_POS_MSB    12

// Event bits, shared by sticky status and mask
`define SIC_EV_OC         0
`define SIC_EV_OT         1
`define SIC_EV_UV         2
`define SIC_EV_HOME       3
`define SIC_EV_W          4

// Control register fields and reset values
`define SIC_CTRL_INHIBIT  0
`define SIC_CTRL_RST      1'h0
`define SIC_MASK_RST      4'h0

// Synchroniser lane positions
`define SIC_IN_CLEAR      0
`define SIC_IN_ENABLE     1
`define SIC_IN_SLEEP      2
`define SIC_IN_STEP       3
`define SIC_IN_DIR        4
`define SIC_IN_RES_LO     5
`define SIC_IN_RES_HI     6
`define SIC_IN_OC         7
`define SIC_IN_OT         8
`define SIC_IN_UV         9
`define SIC_IN_W          10
`define SIC_IN_RST        10'h000

// Indexer table: 32 eighth-step positions, home is the 45 degree entry
`define SIC_POS_W         5
`define SIC_POS_HOME      5'h04
`define SIC_POS_QUARTER   5'h08
`define SIC_STEP_FULL     5'h08

`endif

// File: sic_phase_rom.v
// Winding current lookup for both phases, registered read data
`timescale 1ns/10ps
module sic_phase_rom
(
  input  wire       clk,      // Core clock
  input  wire       rst_n,    // Synchronised reset, active low
  input  wire [4:0] addr_a,   // Table index for winding A
  input  wire [4:0] addr_b,   // Table index for winding B
  output reg  [7:0] pct_a,    // Winding A current, signed percent
  output reg  [7:0] pct_b     // Winding B current, signed percent
);

  // Magnitude of one quarter wave, k = 0..8
  function [7:0] sic_mag;
    input [3:0] k;
    begin
      case (k)
        4'h0:    sic_mag = 8'h64;
        4'h1:    sic_mag = 8'h62;
        4'h2:    sic_mag = 8'h5c;
        4'h3:    sic_mag = 8'h53;
        4'h4:    sic_mag = 8'h47;
        4'h5:    sic_mag = 8'h38;
        4'h6:    sic_mag = 8'h26;
        4'h7:    sic_mag = 8'h14;
        default: sic_mag = 8'h00;
      endcase
    end
  endfunction

  // Signed cosine-like entry; quadrant picks mirror and sign
  function [7:0] sic_entry;
    input [4:0] i;
    reg   [3:0] r;
    begin
      r = {1'b0, i[2:0]};
      case (i[4:3])
        2'h0:    sic_entry = sic_mag(r);
        2'h1:    sic_entry = 8'h00 - sic_mag(4'h8 - r);
        2'h2:    sic_entry = 8'h00 - sic_mag(r);
        default: sic_entry = sic_mag(4'h8 - r);
      endcase
    end
  endfunction

  // Registered read ports
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pct_a <= 8'h00;
      pct_b <= 8'h00;
    end
    else
    begin
      pct_a <= sic_entry(addr_a);
      pct_b <= sic_entry(addr_b);
    end
  end

endmodule // sic_phase_rom

// File: sic_indexer_top.v
// Stepper indexer control, enable, sleep and fault handling top level
`timescale 1ns/10ps
`include "sic_consts.vh"
module sic_indexer_top
(
  input  wire        clk,                    // Core clock, 250 MHz
  input  wire        arst_n,                 // Async reset, active low
  input  wire        indexer_clear_low,      // Indexer clear pin
  input  wire        output_drive_on_low,    // Output enable pin
  input  wire        low_power_request_low,  // Sleep request pin
  input  wire        step,                   // Step advance pin
  input  wire        dir,                    // Direction pin
  input  wire        resolution_sel_hi,      // Step mode select, upper
  input  wire        resolution_sel_lo,      // Step mode select, lower
  input  wire        overcurrent_fault,      // Any FET overcurrent flag
  input  wire        overtemp_fault,         // Die over-temperature flag
  input  wire        supply_low_fault,       // Motor supply low flag
  input  wire [7:0]  reg_addr,               // Register byte address
  input  wire [31:0] reg_wdata,              // Register write data
  input  wire        reg_wr,                 // Write strobe
  input  wire        reg_rd,                 // Read strobe
  output reg  [31:0] reg_rdata,              // Read data, cycle after rd
  output reg         bridge_enable,          // Both bridges driving
  output reg         charge_pump_run,        // Gate drive pump running
  output reg         at_origin_low,          // Home indicator, low at home
  output wire [7:0]  current_a_pct,          // Winding A signed percent
  output wire [7:0]  current_b_pct,          // Winding B signed percent
  output reg         irq                     // Level interrupt
);

  // Reset release synchroniser
  reg  rst_meta_reg;                         // First reset stage
  reg  rst_n_sync;                           // Released reset copy

  // Release reset two edges after arst_n rises
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // Pin synchronisers
  wire [`SIC_IN_W-1:0] pin_raw;              // Raw pin lanes
  reg  [`SIC_IN_W-1:0] pin_meta_reg;         // First stage, not read
  reg  [`SIC_IN_W-1:0] pin_sync_reg;         // Safe synchronised copy

  assign pin_raw = {supply_low_fault, overtemp_fault, overcurrent_fault,
                    resolution_sel_hi, resolution_sel_lo, dir, step,
                    low_power_request_low, output_drive_on_low,
                    indexer_clear_low};

  // Two flip-flops per lane; only stage two is used by logic
  genvar g;
  generate
    for (g = 0; g < `SIC_IN_W; g = g + 1)
    begin : g_sync
      always @(posedge clk or negedge rst_n_sync)
      begin
        if (!rst_n_sync)
        begin
          pin_meta_reg[g] <= 1'b0;
          pin_sync_reg[g] <= 1'b0;
        end
        else
        begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
        end
      end
    end
  endgenerate

  // Decoded synchronised conditions
  wire clear_on = ~pin_sync_reg[`SIC_IN_CLEAR];   // Clear asserted
  wire en_on    = ~pin_sync_reg[`SIC_IN_ENABLE];  // Enable asserted
  wire asleep   = ~pin_sync_reg[`SIC_IN_SLEEP];   // Sleep asserted
  wire step_s   = pin_sync_reg[`SIC_IN_STEP];     // Step level
  wire dir_s    = pin_sync_reg[`SIC_IN_DIR];      // Direction level
  // Single flag covers every short type and both current directions,
  // and does not depend on the regulation sense path
  wire oc_s     = pin_sync_reg[`SIC_IN_OC];
  wire ot_s     = pin_sync_reg[`SIC_IN_OT];       // Over-temperature
  wire uv_s     = pin_sync_reg[`SIC_IN_UV];       // Supply low
  wire [1:0] res_mode = {pin_sync_reg[`SIC_IN_RES_HI],
                         pin_sync_reg[`SIC_IN_RES_LO]};

  // Internal state
  reg  step_d_reg;                           // Step level, last cycle
  reg  [`SIC_POS_W-1:0] pos_reg;             // Indexer position
  reg  [`SIC_POS_W-1:0] pos_next;            // Next position
  reg  oc_latch_reg;                         // Overcurrent latch
  reg  oc_armed_reg;                         // Enable seen high after OC
  reg  ot_d_reg;                             // Overtemp, last cycle
  reg  uv_d_reg;                             // Undervoltage, last cycle
  reg  home_d_reg;                           // At home, last cycle
  reg  ctrl_inhibit_reg;                     // Software drive inhibit
  reg  [`SIC_EV_W-1:0] irq_stat_reg;         // Sticky events
  reg  [`SIC_EV_W-1:0] irq_mask_reg;         // Event mask
  reg  [`SIC_EV_W-1:0] ev_set;               // Events this cycle
  reg  [`SIC_POS_W-1:0] step_inc;            // Increment per step

  wire step_edge = step_s & ~step_d_reg;
  wire at_home   = (pos_reg == `SIC_POS_HOME);
  // Homing conditions: clear pin, overtemp, undervoltage
  wire go_home   = clear_on | ot_s | uv_s;

  // Next indexer position
  always @*
  begin
    // Full step moves eight table entries, eighth step moves one
    step_inc = `SIC_STEP_FULL >> res_mode;
    pos_next = pos_reg;
    if (asleep)
    begin
      pos_next = pos_reg;
    end
    else if (go_home)
    begin
      // Steps during clear, overtemp or undervoltage are dropped, not queued
      pos_next = `SIC_POS_HOME;
    end
    else if (step_edge)
    begin
      // Enable pin is not consulted, so stepping goes on with
      // outputs floating
      if (dir_s)
        pos_next = pos_reg + step_inc;
      else
        pos_next = pos_reg - step_inc;
    end
  end

  // Indexer, edge detector and fault history
  always @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      step_d_reg <= 1'b0;
      pos_reg    <= `SIC_POS_HOME;
      ot_d_reg   <= 1'b0;
      uv_d_reg   <= 1'b0;
      home_d_reg <= 1'b1;
    end
    else
    begin
      // Track step level even asleep so wake gives no false edge
      step_d_reg <= step_s;
      pos_reg    <= pos_next;
      ot_d_reg   <= ot_s;
      uv_d_reg   <= uv_s;
      home_d_reg <= at_home;
    end
  end

  // Overcurrent latch; cleared by enable high then low
  always @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      oc_latch_reg <= 1'b0;
      oc_armed_reg <= 1'b0;
    end
    else if (asleep)
    begin
      // Pins ignored while asleep; latch is held as it is
      oc_latch_reg <= oc_latch_reg;
    end
    else if (oc_s)
    begin
      // A new fault wins over a clearing toggle
      oc_latch_reg <= 1'b1;
      oc_armed_reg <= 1'b0;
    end
    else if (oc_latch_reg && !en_on)
    begin
      oc_armed_reg <= 1'b1;
    end
    else if (oc_latch_reg && oc_armed_reg && en_on)
    begin
      oc_latch_reg <= 1'b0;
      oc_armed_reg <= 1'b0;
    end
  end

  // Driver outputs and home indicator
  always @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      bridge_enable   <= 1'b0;
      charge_pump_run <= 1'b0;
      at_origin_low   <= 1'b0;
    end
    else
    begin
      // Every condition must agree before the bridges drive
      bridge_enable   <= ~clear_on & en_on & ~asleep & ~oc_latch_reg &
                         ~oc_s & ~ot_s & ~uv_s & ~ctrl_inhibit_reg;
      // Pump stops asleep and with the supply gone
      charge_pump_run <= ~asleep & ~uv_s;
      at_origin_low   <= ~at_home;
    end
  end

  // Winding current lookup; B lags A by a quarter wave
  sic_phase_rom u_rom
  (
    .clk    (clk),
    .rst_n  (rst_n_sync),
    .addr_a (pos_reg),
    .addr_b (pos_reg - `SIC_POS_QUARTER),
    .pct_a  (current_a_pct),
    .pct_b  (current_b_pct)
  );

  // Rising edges of fault and home conditions
  always @*
  begin
    ev_set = {`SIC_EV_W{1'b0}};
    ev_set[`SIC_EV_OC]   = oc_s & ~oc_latch_reg & ~asleep;
    ev_set[`SIC_EV_OT]   = ot_s & ~ot_d_reg;
    ev_set[`SIC_EV_UV]   = uv_s & ~uv_d_reg;
    ev_set[`SIC_EV_HOME] = at_home & ~home_d_reg;
  end

  wire rd_stat = reg_rd & (reg_addr == `SIC_OFS_IRQ_STAT);  // Clear read

  // Software registers and sticky events
  always @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ctrl_inhibit_reg <= `SIC_CTRL_RST;
      irq_mask_reg     <= `SIC_MASK_RST;
      irq_stat_reg     <= {`SIC_EV_W{1'b0}};
      irq              <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `SIC_OFS_CTRL)
        ctrl_inhibit_reg <= reg_wdata[`SIC_CTRL_INHIBIT];
      if (reg_wr && reg_addr == `SIC_OFS_IRQ_MASK)
        irq_mask_reg <= reg_wdata[`SIC_EV_W-1:0];
      // Set wins over a clear-on-read in the same cycle
      if (rd_stat)
        irq_stat_reg <= ev_set;
      else
        irq_stat_reg <= irq_stat_reg | ev_set;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data, valid the cycle after the strobe only
  always @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        `SIC_OFS_STATUS:
        begin
          reg_rdata[`SIC_ST_DRIVE]  <= bridge_enable;
          reg_rdata[`SIC_ST_ASLEEP] <= asleep;
          reg_rdata[`SIC_ST_OC]     <= oc_latch_reg;
          reg_rdata[`SIC_ST_OT]     <= ot_s;
          reg_rdata[`SIC_ST_UV]     <= uv_s;
          reg_rdata[`SIC_ST_HOME]   <= at_home;
          reg_rdata[`SIC_ST_POS_MSB:`SIC_ST_POS_LSB] <= pos_reg;
        end
        `SIC_OFS_IRQ_STAT: reg_rdata[`SIC_EV_W-1:0] <= irq_stat_reg;
        `SIC_OFS_IRQ_MASK: reg_rdata[`SIC_EV_W-1:0] <= irq_mask_reg;
        `SIC_OFS_CTRL:     reg_rdata[`SIC_CTRL_INHIBIT] <= ctrl_inhibit_reg;
        default:           reg_rdata <= 32'h0000_0000;  // Unmapped
      endcase
    end
  end

endmodule // sic_indexer_top

// File: sic_ctrl_model.sv
// Motion controller model: issues spaced step pulses on request
`timescale 1ns/10ps
module sic_ctrl_model
(
  input  wire logic       clk,    // Core clock
  input  wire logic       go,     // Start a burst of steps
  input  wire logic [5:0] n,      // Steps in the burst
  output logic            step,   // Step pin
  output logic            busy    // Burst in progress
);
  logic [2:0] ph_reg = 3'h0;      // Phase within one pulse
  logic [5:0] left_reg = 6'h00;   // Pulses still to send
  initial step = 1'b0;
  initial busy = 1'b0;

  // Four cycles high, four low: safely over the three-cycle minimum
  always @(posedge clk)
  begin
    if (go && !busy)
    begin
      left_reg <= n;
      busy     <= (n != 6'h00);
      ph_reg   <= 3'h0;
    end
    else if (busy)
    begin
      step   <= ~ph_reg[2];
      ph_reg <= ph_reg + 3'h1;
      // Last low phase ends the pulse
      if (ph_reg == 3'h7)
      begin
        left_reg <= left_reg - 6'h01;
        busy     <= (left_reg != 6'h01);
      end
    end
  end
endmodule // sic_ctrl_model

// File: sic_indexer_monitor.sv
// Checker for bridge enable, home indicator and fault handling
`timescale 1ns/10ps
module sic_indexer_monitor
(
  input wire logic clk,                   // Core clock
  input wire logic arst_n,                // Async reset
  input wire logic indexer_clear_low,     // Clear pin
  input wire logic output_drive_on_low,   // Enable pin
  input wire logic low_power_request_low, // Sleep pin
  input wire logic overcurrent_fault,     // Overcurrent flag
  input wire logic overtemp_fault,        // Overtemp flag
  input wire logic supply_low_fault,      // Supply low flag
  input wire logic bridge_enable,         // Bridges driving
  input wire logic charge_pump_run,       // Pump running
  input wire logic at_origin_low,         // Home indicator
  input wire logic irq                    // Interrupt
);
  // Pins reach the bridge register three edges after a change
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_clear_off: assert property ((!indexer_clear_low)[*3] |=>
    !bridge_enable) else $error("bridge on during clear");
  a_enable_float: assert property (output_drive_on_low[*3] |=>
    !bridge_enable) else $error("bridge on while disabled");
  a_sleep_stop: assert property ((!low_power_request_low)[*3] |=>
    !bridge_enable && !charge_pump_run) else $error("sleep not off");
  a_temp_off: assert property (overtemp_fault[*3] |=>
    !bridge_enable) else $error("bridge on in overtemp");
  a_supply_off: assert property (supply_low_fault[*3] |=>
    !bridge_enable && !charge_pump_run) else $error("uv not off");
  // Home indicator needs one extra edge behind the position
  // Sleep freezes the indexer, so clear only homes while awake
  a_clear_home: assert property ((!indexer_clear_low &&
    low_power_request_low)[*5] |=> !at_origin_low)
    else $error("clear did not home");
  a_sleep_freeze: assert property ((!low_power_request_low)[*5] |=>
    $stable(at_origin_low)) else $error("moved while asleep");
  // Latch holds while the enable pin never goes high
  a_oc_latched: assert property ((overcurrent_fault &&
    low_power_request_low && !output_drive_on_low)[*3] ##1
    (!output_drive_on_low)[*4] |=> !bridge_enable)
    else $error("overcurrent latch lost");
  a_enable_cause: assert property (bridge_enable |->
    $past(indexer_clear_low, 3) && !$past(output_drive_on_low, 3) &&
    $past(low_power_request_low, 3) && !$past(overtemp_fault, 3) &&
    !$past(supply_low_fault, 3)) else $error("bridge on without cause");

  c_home: cover property ($fell(at_origin_low));
  c_oc: cover property ($rose(overcurrent_fault) ##6 !bridge_enable);
  c_irq: cover property ($rose(irq));
endmodule // sic_indexer_monitor

bind sic_indexer_top sic_indexer_monitor u_mon
(
  .clk                   (clk),
  .arst_n                (arst_n),
  .indexer_clear_low     (indexer_clear_low),
  .output_drive_on_low   (output_drive_on_low),
  .low_power_request_low (low_power_request_low),
  .overcurrent_fault     (overcurrent_fault),
  .overtemp_fault        (overtemp_fault),
  .supply_low_fault      (supply_low_fault),
  .bridge_enable         (bridge_enable),
  .charge_pump_run       (charge_pump_run),
  .at_origin_low         (at_origin_low),
  .irq                   (irq)
);

// File: stepper_indexer_control_protect_tb.sv
// Self-checking bench for the stepper indexer control block
`timescale 1ns/10ps
module stepper_indexer_control_protect_tb;
  logic        clk = 1'b0;              // Core clock
  logic        arst_n = 1'b0;           // Async reset
  logic        clr_n = 1'b1;            // Clear pin
  logic        drv_n = 1'b0;            // Enable pin
  logic        slp_n = 1'b1;            // Sleep pin
  logic        dir, hi, lo, oc, ot, uv; // Other pins
  logic        wr, rd, go;              // Strobes
  logic [7:0]  addr;                    // Register address
  logic [31:0] wdata, d;                // Write data, read result
  logic [5:0]  n_req;                   // Burst length
  wire  [31:0] rdata;                   // Read data
  wire  [7:0]  ia, ib;                  // Winding currents
  wire         br, cp, org_n, irq;      // Outputs
  wire         step, busy;              // Model pins
  int          fails = 0;               // Mismatches
  int          checks = 0;              // Comparisons
  int          cyc = 0;                 // Cycle count
  // Rows: clear, enable, sleep, ot, uv, expected bridge
  logic [5:0]  rows [7] = '{6'b101001, 6'b001000, 6'b111000,
    6'b100000, 6'b101100, 6'b101010, 6'b101001};

  sic_indexer_top uut (.clk(clk), .arst_n(arst_n),
    .indexer_clear_low(clr_n), .output_drive_on_low(drv_n),
    .low_power_request_low(slp_n), .step(step), .dir(dir),
    .resolution_sel_hi(hi), .resolution_sel_lo(lo),
    .overcurrent_fault(oc), .overtemp_fault(ot),
    .supply_low_fault(uv), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .bridge_enable(br),
    .charge_pump_run(cp), .at_origin_low(org_n), .current_a_pct(ia),
    .current_b_pct(ib), .irq(irq));
  sic_ctrl_model u_ctl (.clk(clk), .go(go), .n(n_req), .step(step),
    .busy(busy));

  initial forever #2 clk = ~clk;

  // Cut a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    // Taken at the edge that closes the data cycle
    @(posedge clk) d = rdata;
  endtask
  task automatic steps(input logic [5:0] k);
    int t;
    @(posedge clk) {n_req, go} <= {k, 1'b1};
    @(posedge clk) go <= 1'b0;
    #1 t = 0;
    while (busy && t < 600)
    begin
      @(posedge clk);
      t++;
    end
    wt(6);
  endtask
  task automatic oc_hit();
    oc <= 1'b1;
    wt(4);
    oc <= 1'b0;
    wt(6);
  endtask
  // Enable pin high then low clears the overcurrent latch
  task automatic toggle_en();
    drv_n <= 1'b1;
    wt(6);
    drv_n <= 1'b0;
    wt(6);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    {dir, hi, lo, oc, ot, uv, wr, rd, go} = '0;
    {addr, wdata, n_req} = '0;
    wt(16);
    arst_n <= 1'b1;
    wt(8);
    foreach (rows[i])
    begin
      {clr_n, drv_n, slp_n, ot, uv} <= rows[i][5:1];
      wt(6);
      chk("bridge_enable", br, rows[i][0]);
      chk("charge_pump_run", cp, rows[i][3] & ~rows[i][1]);
    end
    // Outputs floating while stepping each mode round to home
    drv_n <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      {hi, lo, dir} <= {m[1:0], m[0]};
      steps((6'd4 << m) - 1);
      chk("at_origin_low", org_n, 1);
      if (m == 0)
      begin
        chk("current_a_pct", ia, 8'hb9);
        chk("current_b_pct", ib, 8'h47);
      end
      steps(1);
      chk("at_origin_low", org_n, 0);
    end
    clr_n <= 1'b0;
    wt(4);
    steps(3);
    clr_n <= 1'b1;
    wt(6);
    chk("at_origin_low", org_n, 0);
    steps(1);
    slp_n <= 1'b0;
    wt(4);
    steps(31);
    slp_n <= 1'b1;
    wt(6);
    chk("at_origin_low", org_n, 1);
    drv_n <= 1'b0;
    wt(6);
    chk("bridge_enable", br, 1);
    ot <= 1'b1;
    wt(6);
    chk("at_origin_low", org_n, 0);
    chk("bridge_enable", br, 0);
    ot <= 1'b0;
    wt(6);
    chk("bridge_enable", br, 1);
    wr_reg(8'h08, 32'h1);
    oc_hit();
    chk("bridge_enable", br, 0);
    chk("irq", irq, 1);
    rd_reg(8'h04);
    // Overcurrent, overtemp, undervoltage and home entry all seen
    chk("irq_stat", d[3:0], 4'hf);
    wt(2);
    chk("irq", irq, 0);
    toggle_en();
    chk("bridge_enable", br, 1);
    wr_reg(8'h08, 32'h0);
    oc_hit();
    chk("irq", irq, 0);
    rd_reg(8'h04);
    chk("irq_stat", d[3:0], 4'h1);
    toggle_en();
    rd_reg(8'h00);
    // Driving, at home, position four, no faults
    chk("status", d, 32'h0000_0421);
    rd_reg(8'h10);
    chk("unmapped", d, 0);
    wr_reg(8'h0c, 32'h1);
    wt(4);
    chk("bridge_enable", br, 0);
    rd_reg(8'h0c);
    chk("ctrl", d, 1);
    wr_reg(8'h0c, 32'h0);
    // Second reset in mid-run returns the indexer home
    steps(1);
    arst_n <= 1'b0;
    wt(2);
    chk("bridge_enable", br, 0);
    arst_n <= 1'b1;
    wt(10);
    chk("at_origin_low", org_n, 0);
    chk("bridge_enable", br, 1);
    conclude();
  end
endmodule // stepper_indexer_control_protect_tb
